/* hdl/sram_port_host.v */
/*
  Host controller for one port of an asynchronous 1K x 8 dual-port RAM.
  Takes single read or write requests on a user port and drives the
  RAM's address, select, output enable, read/write strobe and data pins.
  Assumes the RAM pins are wired directly and inputs are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_consts.vh"

module sram_port_host #(
  parameter ADDR_W        = `ADDR_W,
  parameter DATA_W        = `DATA_W,
  parameter MASTER_SLAVE  = 1,
  parameter SAME_ADDR_BSY = 1
)(
  input  wire              clk,
  input  wire              rst,
  input  wire              req_valid,
  input  wire              req_write,
  input  wire [ADDR_W-1:0] req_addr,
  input  wire [DATA_W-1:0] req_wdata,
  output reg               req_ready,
  output reg               rsp_valid,
  output reg  [DATA_W-1:0] rsp_rdata,
  output reg  [ADDR_W-1:0] ram_addr,
  output reg               ram_sel_n,
  output reg               ram_oe_n,
  output reg               ram_rw_n,
  input  wire [DATA_W-1:0] ram_data_in,
  output reg  [DATA_W-1:0] ram_data_out,
  output reg               ram_data_oe
);

  // ------------------------------------------------------------
  // Timing in clock cycles
  // ------------------------------------------------------------
  // Worked out wide, then cut to the counter width on purpose;
  // every count fits in four bits at a 50 ns clock
  localparam integer RD_WAIT_I = `CEIL_CYC(`ADDRESS_TO_DATA_DELAY
                               + (SAME_ADDR_BSY ? `BUSY_RELEASE_TO_DATA_NS : 0));
  localparam integer WR_PRE_I  = MASTER_SLAVE ? `CEIL_CYC(`BUSY_FROM_ADDRESS_NS) : 1;
  localparam integer WR_PW_A_I = `CEIL_CYC(`WRITE_PULSE_NS);
  localparam integer WR_PW_B_I = `CEIL_CYC(`OUTPUT_FLOAT_NS + `DATA_SETUP_TO_WRITE_END);
  localparam integer FLOAT_I   = `CEIL_CYC(`OUTPUT_FLOAT_NS);
  localparam integer STBY_I    = `CEIL_CYC(`DESELECT_TO_STANDBY);
  // Every count must be one or more; a zero would wrap the counter
  // and stretch the phase to sixteen cycles
  localparam [3:0] RD_WAIT = RD_WAIT_I[3:0];
  localparam [3:0] WR_PRE  = WR_PRE_I[3:0];
  localparam [3:0] WR_PW_A = WR_PW_A_I[3:0];
  localparam [3:0] WR_PW_B = WR_PW_B_I[3:0];
  localparam [3:0] WR_PW   = (WR_PW_A > WR_PW_B) ? WR_PW_A : WR_PW_B;
  localparam [3:0] FLOAT_C = FLOAT_I[3:0];
  localparam [3:0] STBY_C  = STBY_I[3:0];

  // ------------------------------------------------------------
  // Access shape
  // ------------------------------------------------------------
  // Read: select and output enable low together, data taken
  // RD_WAIT+1 edges later, on the edge that raises them again.
  // Write: select low with output enable high, WR_PRE cycles of
  // busy wait, strobe low for WR_PW cycles, data held one more.
  // After either, FLOAT_C or STBY_C idle cycles before ready.
  // Slowest-grade figures throughout; faster parts only gain slack.

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_RD    = 3'h1;
  localparam [2:0] S_RDEND = 3'h2;
  localparam [2:0] S_WPRE  = 3'h3;
  localparam [2:0] S_WPUL  = 3'h4;
  localparam [2:0] S_WREC  = 3'h5;
  localparam [2:0] S_GAP   = 3'h6;

  reg [2:0]        state_reg;
  reg [2:0]        state_next;
  reg [3:0]        cnt_reg;
  reg [3:0]        cnt_next;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always @*
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      S_IDLE:
        // Gated by ready so the first edge after reset takes nothing
        if (req_valid && req_ready)
        begin
          // Address loaded on the same edge that takes select low
          state_next = req_write ? S_WPRE : S_RD;
          cnt_next   = req_write ? WR_PRE : RD_WAIT;
        end
      S_RD:
        if (cnt_reg == 4'h1)
          state_next = S_RDEND;
        else
          cnt_next = cnt_reg - 4'h1;
      S_RDEND:
      begin
        // Device float time before host may drive again
        state_next = S_GAP;
        cnt_next   = FLOAT_C;
      end
      S_WPRE:
        if (cnt_reg == 4'h1)
        begin
          state_next = S_WPUL;
          cnt_next   = WR_PW;
        end
        else
          cnt_next = cnt_reg - 4'h1;
      S_WPUL:
        if (cnt_reg == 4'h1)
          state_next = S_WREC;
        else
          cnt_next = cnt_reg - 4'h1;
      S_WREC:
      begin
        state_next = S_GAP;
        cnt_next   = STBY_C;
      end
      S_GAP:
        if (cnt_reg == 4'h1)
          state_next = S_IDLE;
        else
          cnt_next = cnt_reg - 4'h1;
      default:
        state_next = S_IDLE;
    endcase
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      cnt_reg   <= 4'h0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ram_addr     <= {ADDR_W{1'b0}};
      ram_sel_n    <= 1'b1;
      ram_oe_n     <= 1'b1;
      ram_rw_n     <= 1'b1;
      ram_data_out <= {DATA_W{1'b0}};
      ram_data_oe  <= 1'b0;
      req_ready    <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_rdata    <= {DATA_W{1'b0}};
    end
    else
    begin
      // Pins decode state_next so they switch with the state, except data
      // enable, which also decodes state_reg and stays on a cycle longer; no decode glitches
      req_ready <= (state_next == S_IDLE);
      rsp_valid <= 1'b0;
      if (state_reg == S_IDLE && req_valid && req_ready)
      begin
        // Address moves only with strobe high, on the edge that takes select low
        ram_addr <= req_addr;
        if (req_write)
          ram_data_out <= req_wdata;
      end
      // Select low for the whole access, from the edge that loads the address
      ram_sel_n <= ~(state_next == S_RD || state_next == S_RDEND ||
                     state_next == S_WPRE || state_next == S_WPUL);
      ram_oe_n  <= ~(state_next == S_RD || state_next == S_RDEND);
      // Strobe falls a cycle after select, rises on the same edge as select to end the write
      ram_rw_n  <= ~(state_next == S_WPUL);
      // Drive data only with output enable high a full pulse earlier
      ram_data_oe <= (state_next == S_WPUL) || (state_reg == S_WPUL);
      if (state_reg == S_RDEND)
      begin
        rsp_rdata <= ram_data_in;
        rsp_valid <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* inc/sram_host_consts.vh */
/*
  Timing constants for the host-side controller of one port of an
  asynchronous 1K x 8 dual-port static RAM.
  Assumes a 20 MHz controller clock (50 ns period).
*/
`ifndef SRAM_HOST_CONSTS_VH
`define SRAM_HOST_CONSTS_VH

// ------------------------------------------------------------
// Clock
// ------------------------------------------------------------
`define CLK_PERIOD_NS          50

// ------------------------------------------------------------
// Device geometry
// ------------------------------------------------------------
`define ADDR_W                 10
`define DATA_W                 8

// ------------------------------------------------------------
// Device timing, slowest grade, in ns
// ------------------------------------------------------------
`define READ_CYCLE_NS          100
`define ADDRESS_TO_DATA_DELAY  100
`define SELECT_TO_DATA_DELAY   100
`define DRIVE_ENABLE_TO_DATA_DELAY 40
`define OUTPUT_FLOAT_NS        40
`define BUSY_RELEASE_TO_DATA_NS 65
`define WRITE_CYCLE_NS         100
`define SELECT_TO_WRITE_END_NS 90
`define WRITE_PULSE_NS         55
`define DATA_SETUP_TO_WRITE_END 40
`define BUSY_FROM_ADDRESS_NS   50
`define DESELECT_TO_STANDBY    50

// ------------------------------------------------------------
// Cycle counts (least times rounded up)
// ------------------------------------------------------------
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* verification/sram_dev_model.sv */
/*
  Behavioural 1K x 8 RAM port, no clock.
  Assumes the bench resolves the data bus from both drivers.
*/
`timescale 1ns/1ps
`default_nettype none
module sram_dev_model #(
  parameter ACC = 165
)(
  input  wire logic [9:0] ram_addr,
  input  wire logic       ram_sel_n,
  input  wire logic       ram_oe_n,
  input  wire logic       ram_rw_n,
  input  wire logic [7:0] bus,
  output wire logic       dev_oe,
  output wire logic [7:0] dev_q
);
  reg [7:0] mem [0:1023];
  reg       valid;
  assign dev_oe = !ram_sel_n && !ram_oe_n && ram_rw_n;
  always @*
    if (!ram_sel_n && !ram_rw_n)
      mem[ram_addr] = bus;
  // Worst access plus busy release; stale data shows inverted
  always @(ram_addr or dev_oe)
  begin
    valid = 1'b0;
    valid <= #(ACC) dev_oe;
  end
  assign dev_q = valid ? mem[ram_addr] : ~mem[ram_addr];
endmodule
`default_nettype wire

/* verification/sram_host_chk_sva.sv */
/*
  Pin checker for the host side of one RAM port.
  Assumes binding to every sram_port_host instance at default timing.
*/
`timescale 1ns/1ps
`default_nettype none
module sram_host_chk #(
  parameter ADDR_W = 10,
  parameter DATA_W = 8
)(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              rsp_valid,
  input wire logic [ADDR_W-1:0] ram_addr,
  input wire logic              ram_sel_n,
  input wire logic              ram_oe_n,
  input wire logic              ram_rw_n,
  input wire logic [DATA_W-1:0] ram_data_out,
  input wire logic              ram_data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_read_ctrl: assert property (!ram_oe_n |-> !ram_sel_n && ram_rw_n)
    else $error("output enable low outside a read");
  chk_addr_guard: assert property ($changed(ram_addr) |-> ram_sel_n || ram_rw_n)
    else $error("address moved during a write");
  chk_bus_turn: assert property (ram_data_oe |-> ram_oe_n)
    else $error("host drives data while the RAM may drive");
  chk_strobe_wait: assert property ($fell(ram_rw_n) |-> $stable(ram_addr) && !$past(ram_sel_n))
    else $error("strobe fell before the busy wait");
  chk_pulse_width: assert property ($fell(ram_rw_n) |-> (!ram_rw_n && ram_data_oe)[*2])
    else $error("write pulse too short");
  chk_data_hold: assert property ($rose(ram_rw_n) |-> ram_data_oe && $stable(ram_data_out))
    else $error("write data not held");
  chk_write_end: assert property ($rose(ram_rw_n) |-> !$past(ram_sel_n, 2) && $stable(ram_addr))
    else $error("select or address too short before write end");
  chk_read_wait: assert property (rsp_valid |-> !$past(ram_oe_n) && !$past(ram_sel_n, 4))
    else $error("read data taken too early");
endmodule
bind sram_port_host sram_host_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_inst (
  .clk(clk), .rst(rst), .rsp_valid(rsp_valid), .ram_addr(ram_addr), .ram_sel_n(ram_sel_n),
  .ram_oe_n(ram_oe_n), .ram_rw_n(ram_rw_n), .ram_data_out(ram_data_out),
  .ram_data_oe(ram_data_oe));
`default_nettype wire

/* verification/sram_port_host_tb.sv */
/*
  Self-checking bench for sram_port_host against a behavioural RAM.
  Assumes the default design parameters.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_consts.vh"
module sram_port_host_tb;
  reg        clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  reg  [9:0] req_addr = 10'h000;
  reg  [7:0] req_wdata = 8'h00, last = 8'h00;
  integer    failures = 0, comparisons = 0, i;
  // Access plus busy release in whole cycles, then the sampling edge
  localparam integer RD_LAT = `CEIL_CYC(`ADDRESS_TO_DATA_DELAY + `BUSY_RELEASE_TO_DATA_NS) + 1;
  wire       req_ready, rsp_valid, ram_sel_n, ram_oe_n, ram_rw_n, ram_data_oe, dev_oe;
  wire [7:0] rsp_rdata, ram_data_out, dev_q, bus;
  wire [9:0] ram_addr;
  always #25 clk = ~clk;
  // Undriven bus shows the inverse of its last level
  assign bus = ram_data_oe ? ram_data_out : dev_oe ? dev_q : ~last;
  always @(posedge clk) last <= bus;
  sram_port_host sram_port_host_inst (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ram_addr(ram_addr), .ram_sel_n(ram_sel_n),
    .ram_oe_n(ram_oe_n), .ram_rw_n(ram_rw_n), .ram_data_in(bus), .ram_data_out(ram_data_out),
    .ram_data_oe(ram_data_oe));
  sram_dev_model sram_dev_model_inst (.ram_addr(ram_addr), .ram_sel_n(ram_sel_n),
    .ram_oe_n(ram_oe_n), .ram_rw_n(ram_rw_n), .bus(bus), .dev_oe(dev_oe), .dev_q(dev_q));
  task check(input string what, input [9:0] seen, input [9:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task print_verdict;
  begin
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task send(input w, input [9:0] a, input [7:0] d);
    integer n;
  begin
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n = n + 1;
    end
    check("ready", {9'h000, req_ready}, 10'h001);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
  end
  endtask
  task rd(input [9:0] a, input [7:0] e);
    integer n;
  begin
    send(1'b0, a, 8'h00);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n = n + 1;
    end
    check("read latency", n[9:0], RD_LAT[9:0]);
    check("read data", {2'h0, rsp_rdata}, {2'h0, e});
  end
  endtask
  task test_fill;
  begin
    for (i = 0; i < 4; i = i + 1)
      send(1'b1, 10'h155 * i, 8'h5a + 8'h33 * i);
    for (i = 0; i < 4; i = i + 1)
      rd(10'h155 * i, 8'h5a + 8'h33 * i);
    $display("test_fill done");
  end
  endtask
  task test_overwrite;
  begin
    send(1'b1, 10'h155, 8'hc3);
    send(1'b1, 10'h155, 8'h3c);
    rd(10'h155, 8'h3c);
    $display("test_overwrite done");
  end
  endtask
  task test_refused;
  begin
    send(1'b1, 10'h002, 8'h11);
    req_valid = 1'b1;
    req_wdata = 8'h77;
    check("busy ready", {9'h000, req_ready}, 10'h000);
    @(negedge clk);
    req_valid = 1'b0;
    rd(10'h002, 8'h11);
    $display("test_refused done");
  end
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    test_fill;
    test_overwrite;
    test_refused;
    print_verdict;
  end
  initial
  begin
    #100000;
    failures = failures + 1;
    print_verdict;
  end
endmodule
`default_nettype wire
